// ---- include/psumb_pkg.sv ----
`default_nettype none
package psumb_pkg;
	// request function codes
	localparam logic [7:0] FC_READ = 8'h03;
	localparam logic [7:0] FC_WRITE_ONE = 8'h06;
	localparam logic [7:0] FC_WRITE_MANY = 8'h10;
	// exception codes, and the flag ored into an echoed function code
	localparam logic [7:0] EXC_NONE = 8'h00;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_DATA = 8'h03;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	// register counts per value
	localparam logic [7:0] CNT_NONE = 8'h00;
	localparam logic [7:0] CNT_ONE = 8'h01;
	localparam logic [7:0] CNT_TWO = 8'h02;
	localparam logic [7:0] CNT_FOUR = 8'h04;
	// register addresses
	localparam logic [15:0] ADDR_STATUS = 16'h10D0;
	localparam logic [15:0] ADDR_OUT_WR = 16'h10F0;
	localparam logic [15:0] ADDR_OUT_RD = 16'h1100;
	localparam logic [15:0] ADDR_MEAS_I = 16'h2010;
	localparam logic [15:0] ADDR_MEAS_V = 16'h2020;
	localparam logic [15:0] ADDR_MEAS_P = 16'h2030;
	localparam logic [15:0] ADDR_CUR_WR = 16'h3010;
	localparam logic [15:0] ADDR_CUR_RD = 16'h3020;
	localparam logic [15:0] ADDR_VOLT_WR = 16'h3030;
	localparam logic [15:0] ADDR_VOLT_RD = 16'h3040;
	localparam logic [15:0] ADDR_PWR_WR = 16'h3050;
	localparam logic [15:0] ADDR_PWR_RD = 16'h3060;
	localparam logic [15:0] ADDR_TRIP_WR = 16'h4010;
	localparam logic [15:0] ADDR_TRIP_RD = 16'h4020;
	// status word bit positions
	localparam int ST_STANDBY = 0;
	localparam int ST_LIVE = 1;
	localparam int ST_CUR_TRIP = 4;
	localparam int ST_VHI_TRIP = 5;
	localparam int ST_PWR_TRIP = 6;
	localparam int ST_SENSE_LOST = 7;
	localparam int ST_VLO_TRIP = 8;
	localparam int ST_SHUTDOWN = 9;
	localparam int ST_START_FAIL = 12;
	localparam int ST_START_PEND = 13;
	localparam int ST_I_LIMIT = 16;
	localparam int ST_V_LIMIT = 17;
	localparam int ST_REG_LOST = 29;
	localparam int ST_PHASE_MISS = 31;
	localparam int ST_FAN_STALL = 33;
	// questionable word positions fed from the status word
	localparam int QW_CUR_TRIP = 1;
	localparam int QW_VHI_TRIP = 2;
	localparam int QW_PWR_TRIP = 3;
	localparam int QW_SENSE_LOST = 6;
	// values after reset and trip filter length
	localparam logic [31:0] TARGET_RST = 32'h00000000;
	localparam logic OUTPUT_RST = 1'b0;
	localparam logic [63:0] STATUS_RST = 64'h0000000000000001;
	localparam int TRIP_SAMPLES = 4;
endpackage
`default_nettype wire

// ---- logic/psumb_regs.sv ----
`default_nettype none
// What this block does
// - status word readable at 0x10D0, function 0x03, four registers
// - status bits follow live conditions, except bit 4 latched until an output write
// - reading the status word changes nothing
// - questionable word bits are a subset of the status word
// - bit 0 standby, bit 1 output active
// - bits 4,5,6,8 trips; bit 7 remote sense out of bounds
// - bit 9 shows an internal shutdown condition
// - bit 12 startup failed, bit 13 startup pending
// - bit 16 current over rating, bit 17 voltage over rating
// - bit 29 out of regulation
// - bit 31 phase missing, bit 33 fan stall, spare bits zero
// - write 1 or 0 at 0x10F0, function 0x06, switches output
// - readback at 0x1100 is 1 only while output active
// - 0x2010 returns last sampled current float, two registers
// - 0x2020 returns voltage, sense voltage when remote sensing
// - 0x2030 returns last sampled power float, two registers
// - current target written 0x3010 function 0x10, read 0x3020
// - voltage target written 0x3030, read 0x3040
// - power target written 0x3050, read 0x3060
// - trip limit 0x4010/0x4020; repeated overcurrent disconnects, faults
module psumb_regs
	import psumb_pkg::*;
#(
	parameter int TRIP_COUNT = TRIP_SAMPLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic [7:0] req_func,
	input wire logic [15:0] req_addr,
	input wire logic [7:0] req_count,
	input wire logic [31:0] req_wdata,
	output logic rsp_valid,
	output logic [7:0] rsp_func,
	output logic [7:0] rsp_exc_code,
	output logic [7:0] rsp_count,
	output logic [63:0] rsp_data,
	input wire logic meas_valid,
	input wire logic [31:0] meas_current,
	input wire logic [31:0] meas_voltage,
	input wire logic [31:0] sense_voltage,
	input wire logic remote_sense_on,
	input wire logic [31:0] meas_power,
	input wire logic voltage_high_trip_flag,
	input wire logic power_trip_flag,
	input wire logic far_sense_lost_flag,
	input wire logic voltage_low_trip_flag,
	input wire logic shutdown_flag,
	input wire logic startup_failed_flag,
	input wire logic startup_pending_flag,
	input wire logic terminal_current_limit_flag,
	input wire logic terminal_voltage_limit_flag,
	input wire logic regulation_lost_flag,
	input wire logic input_phase_missing_flag,
	input wire logic fan_stall_flag,
	output logic power_enable,
	output logic [31:0] current_target,
	output logic [31:0] voltage_target,
	output logic [31:0] power_target,
	output logic [15:0] quest_word
);

	function automatic logic [7:0] map_count(
		input logic [7:0] f,
		input logic [15:0] a
	);
		map_count = CNT_NONE;
		case (f)
			FC_READ: begin
				case (a)
					ADDR_STATUS: map_count = CNT_FOUR;
					ADDR_OUT_RD: map_count = CNT_ONE;
					ADDR_MEAS_I, ADDR_MEAS_V, ADDR_MEAS_P,
					ADDR_CUR_RD, ADDR_VOLT_RD, ADDR_PWR_RD,
					ADDR_TRIP_RD: map_count = CNT_TWO;
					default: map_count = CNT_NONE;
				endcase
			end
			FC_WRITE_ONE: begin
				if (a == ADDR_OUT_WR)
					map_count = CNT_ONE;
			end
			FC_WRITE_MANY: begin
				case (a)
					ADDR_CUR_WR, ADDR_VOLT_WR, ADDR_PWR_WR,
					ADDR_TRIP_WR: map_count = CNT_TWO;
					default: map_count = CNT_NONE;
				endcase
			end
			default: map_count = CNT_NONE;
		endcase
	endfunction

	// floats above zero compare as unsigned integers
	function automatic logic f_above(
		input logic [31:0] a,
		input logic [31:0] b
	);
		if (a[31])
			f_above = 1'b0;
		else if (b[31])
			f_above = |a[30:0];
		else
			f_above = a[30:0] > b[30:0];
	endfunction

	localparam int CW = $clog2(TRIP_COUNT + 1);

	logic [11:0] flag_raw;
	logic [11:0] flag_meta;
	logic [11:0] flag_sync;
	logic [63:0] status_word;
	logic [63:0] next_status;
	logic output_on;
	logic trip_fault;
	logic [31:0] trip_limit;
	logic [31:0] avg_current;
	logic [31:0] avg_voltage;
	logic [31:0] avg_power;
	logic [CW-1:0] over_cnt;
	logic over_now;
	logic trip_now;
	logic func_known;
	logic [7:0] want_count;
	logic [7:0] exc_code;
	logic accept;
	logic wr_out;
	logic wr_many;
	logic [63:0] rd_data;

	assign flag_raw = {fan_stall_flag, input_phase_missing_flag,
		regulation_lost_flag, terminal_voltage_limit_flag,
		terminal_current_limit_flag, startup_pending_flag,
		startup_failed_flag, shutdown_flag, voltage_low_trip_flag,
		far_sense_lost_flag, power_trip_flag, voltage_high_trip_flag};

	// condition pins come from other logic blocks, unsynchronised
	always_ff @(posedge clk) begin
		if (rst) begin
			flag_meta <= '0;
			flag_sync <= '0;
		end else begin
			flag_meta <= flag_raw;
			flag_sync <= flag_meta;
		end
	end

	// request check: function, then address, then count and value
	always_comb begin
		func_known = (req_func == FC_READ) || (req_func == FC_WRITE_ONE)
			|| (req_func == FC_WRITE_MANY);
		want_count = map_count(req_func, req_addr);
		if (!func_known)
			exc_code = EXC_FUNC;
		else if (want_count == CNT_NONE)
			exc_code = EXC_ADDR;
		else if (want_count != req_count)
			exc_code = EXC_DATA;
		else if (req_func == FC_WRITE_ONE && req_wdata[15:1] != '0)
			exc_code = EXC_DATA;
		else
			exc_code = EXC_NONE;
	end

	assign accept = req_valid && (exc_code == EXC_NONE);
	assign wr_out = accept && (req_func == FC_WRITE_ONE);
	assign wr_many = accept && (req_func == FC_WRITE_MANY);

	always_ff @(posedge clk) begin
		if (rst) begin
			current_target <= TARGET_RST;
			voltage_target <= TARGET_RST;
			power_target <= TARGET_RST;
			trip_limit <= TARGET_RST;
		end else if (wr_many) begin
			case (req_addr)
				ADDR_CUR_WR: current_target <= req_wdata;
				ADDR_VOLT_WR: voltage_target <= req_wdata;
				ADDR_PWR_WR: power_target <= req_wdata;
				ADDR_TRIP_WR: trip_limit <= req_wdata;
				default: trip_limit <= trip_limit;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			avg_current <= TARGET_RST;
			avg_voltage <= TARGET_RST;
			avg_power <= TARGET_RST;
		end else if (meas_valid) begin
			avg_current <= meas_current;
			avg_voltage <= remote_sense_on ? sense_voltage
				: meas_voltage;
			avg_power <= meas_power;
		end
	end

	// trip filter counts consecutive samples above the limit
	assign over_now = meas_valid && output_on
		&& f_above(meas_current, trip_limit);
	assign trip_now = over_now
		&& (over_cnt == CW'(TRIP_COUNT - 1));

	always_ff @(posedge clk) begin
		if (rst)
			over_cnt <= '0;
		else if (!output_on || trip_now)
			over_cnt <= '0;
		else if (meas_valid)
			over_cnt <= over_now ? over_cnt + 1'b1 : '0;
	end

	// a trip beats a same-cycle enable
	always_ff @(posedge clk) begin
		if (rst)
			output_on <= OUTPUT_RST;
		else if (trip_now)
			output_on <= 1'b0;
		else if (wr_out)
			output_on <= req_wdata[0];
	end

	always_ff @(posedge clk) begin
		if (rst)
			trip_fault <= 1'b0;
		else if (trip_now)
			trip_fault <= 1'b1;
		else if (wr_out)
			trip_fault <= 1'b0;
	end

	assign power_enable = output_on;

	// live status image, spare bits stay zero
	always_comb begin
		next_status = '0;
		next_status[ST_STANDBY] = ~output_on;
		next_status[ST_LIVE] = output_on;
		next_status[ST_CUR_TRIP] = trip_fault;
		next_status[ST_VHI_TRIP] = flag_sync[0];
		next_status[ST_PWR_TRIP] = flag_sync[1];
		next_status[ST_SENSE_LOST] = flag_sync[2];
		next_status[ST_VLO_TRIP] = flag_sync[3];
		next_status[ST_SHUTDOWN] = flag_sync[4];
		next_status[ST_START_FAIL] = flag_sync[5];
		next_status[ST_START_PEND] = flag_sync[6];
		next_status[ST_I_LIMIT] = flag_sync[7];
		next_status[ST_V_LIMIT] = flag_sync[8];
		next_status[ST_REG_LOST] = flag_sync[9];
		next_status[ST_PHASE_MISS] = flag_sync[10];
		next_status[ST_FAN_STALL] = flag_sync[11];
	end

	always_ff @(posedge clk) begin
		if (rst)
			status_word <= STATUS_RST;
		else
			status_word <= next_status;
	end

	always_comb begin
		quest_word = '0;
		quest_word[QW_CUR_TRIP] = status_word[ST_CUR_TRIP];
		quest_word[QW_VHI_TRIP] = status_word[ST_VHI_TRIP];
		quest_word[QW_PWR_TRIP] = status_word[ST_PWR_TRIP];
		quest_word[QW_SENSE_LOST] = status_word[ST_SENSE_LOST];
	end

	// value sits in the low words, first register most significant
	always_comb begin
		rd_data = '0;
		case (req_addr)
			ADDR_STATUS: rd_data = status_word;
			ADDR_OUT_RD: rd_data[0] = status_word[ST_LIVE];
			ADDR_MEAS_I: rd_data[31:0] = avg_current;
			ADDR_MEAS_V: rd_data[31:0] = avg_voltage;
			ADDR_MEAS_P: rd_data[31:0] = avg_power;
			ADDR_CUR_RD: rd_data[31:0] = current_target;
			ADDR_VOLT_RD: rd_data[31:0] = voltage_target;
			ADDR_PWR_RD: rd_data[31:0] = power_target;
			ADDR_TRIP_RD: rd_data[31:0] = trip_limit;
			default: rd_data = '0;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid <= 1'b0;
			rsp_func <= 8'h00;
			rsp_exc_code <= EXC_NONE;
			rsp_count <= CNT_NONE;
			rsp_data <= '0;
		end else begin
			rsp_valid <= req_valid;
			if (req_valid) begin
				rsp_exc_code <= exc_code;
				rsp_func <= (exc_code == EXC_NONE) ? req_func
					: (req_func | EXC_FLAG);
				rsp_count <= (exc_code == EXC_NONE) ? req_count
					: CNT_NONE;
				rsp_data <= (accept && req_func == FC_READ) ? rd_data
					: {32'h00000000, req_wdata};
			end
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	property p_answer;
		req_valid |=> rsp_valid ##1 !rsp_valid || $past(req_valid);
	endproperty
	a_answer: assert property (p_answer)
		else $error("request not answered in one cycle");
	property p_read_quiet;
		req_valid && req_func == FC_READ && !trip_now |=>
			$stable(output_on) && $stable(current_target)
			&& $stable(trip_limit);
	endproperty
	a_read_quiet: assert property (p_read_quiet)
		else $error("read changed state");
	property p_standby_live;
		status_word[ST_STANDBY] != status_word[ST_LIVE]
			&& status_word[ST_LIVE] == $past(output_on);
	endproperty
	a_standby_live: assert property (p_standby_live)
		else $error("standby and live not exclusive");
	property p_readback;
		req_valid && req_func == FC_READ && req_addr == ADDR_OUT_RD
			&& req_count == CNT_ONE |=>
			rsp_data == {63'h0, $past(status_word[ST_LIVE])};
	endproperty
	a_readback: assert property (p_readback)
		else $error("output readback wrong");
	property p_trip;
		trip_now |=> !output_on && trip_fault
			##1 status_word[ST_CUR_TRIP] && status_word[ST_STANDBY];
	endproperty
	a_trip: assert property (p_trip)
		else $error("trip did not disconnect");
	property p_enable;
		wr_out && req_wdata[0] && !trip_now |=> output_on
			##1 status_word[ST_LIVE];
	endproperty
	a_enable: assert property (p_enable)
		else $error("output write ignored");
	property p_no_change;
		req_valid && exc_code != EXC_NONE && !trip_now |=>
			$stable(output_on) && $stable(voltage_target)
			&& $stable(power_target) && rsp_func[7];
	endproperty
	a_no_change: assert property (p_no_change)
		else $error("refused request changed state");
	property p_unmapped;
		req_valid && func_known
			&& map_count(req_func, req_addr) == CNT_NONE
			|=> rsp_exc_code == EXC_ADDR;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped address not refused");
	property p_subset;
		{quest_word[QW_SENSE_LOST], quest_word[QW_PWR_TRIP],
			quest_word[QW_VHI_TRIP], quest_word[QW_CUR_TRIP]}
			== status_word[ST_SENSE_LOST:ST_CUR_TRIP];
	endproperty
	a_subset: assert property (p_subset)
		else $error("questionable bit differs");
	property p_spare;
		status_word[3:2] == 2'b00 && status_word[63:50] == '0;
	endproperty
	a_spare: assert property (p_spare)
		else $error("spare status bit set");
	property p_sense;
		meas_valid && remote_sense_on |=> avg_voltage == $past(sense_voltage);
	endproperty
	a_sense: assert property (p_sense)
		else $error("sense voltage not selected");
	property p_cv_trip;
		trip_now;
	endproperty
	c_trip: cover property (p_cv_trip);
	property p_cv_status;
		req_valid && req_func == FC_READ && req_addr == ADDR_STATUS;
	endproperty
	c_status: cover property (p_cv_status);
	property p_cv_exc;
		rsp_valid && rsp_exc_code == EXC_DATA;
	endproperty
	c_exc: cover property (p_cv_exc);

endmodule // psumb_regs
`default_nettype wire

// ---- bench/psumb_master.sv ----
`default_nettype none
// modbus master: one value per request, strobe taken at one edge
module psumb_master
	import psumb_pkg::*;
(
	input wire logic clk,
	output var logic req_valid,
	output var logic [7:0] req_func,
	output var logic [15:0] req_addr,
	output var logic [7:0] req_count,
	output var logic [31:0] req_wdata,
	input wire logic rsp_valid,
	input wire logic [7:0] rsp_func,
	input wire logic [7:0] rsp_exc_code,
	input wire logic [7:0] rsp_count,
	input wire logic [63:0] rsp_data
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		req_valid = 1'b0;
		req_func = 8'h00;
		req_addr = 16'h0000;
		req_count = 8'h00;
		req_wdata = 32'h00000000;
	end
	// caller keeps values within range, one, two or four adjacent registers
	task automatic xfer(input logic [7:0] f, input logic [15:0] a,
		input logic [7:0] n, input logic [31:0] w, output logic v,
		output logic [7:0] of, output logic [7:0] oe,
		output logic [7:0] on, output logic [63:0] od);
		@(posedge clk);
		#1;
		req_valid = 1'b1;
		req_func = f;
		req_addr = a;
		req_count = n;
		req_wdata = w;
		@(posedge clk);
		#1;
		v = rsp_valid;
		of = rsp_func;
		oe = rsp_exc_code;
		on = rsp_count;
		od = rsp_data;
		req_valid = 1'b0;
		// released fields show no stale request
		req_func = ~f;
		req_addr = ~a;
		req_count = ~n;
		req_wdata = ~w;
	endtask
endmodule // psumb_master
`default_nettype wire

// ---- bench/test_psumb_regs.sv ----
`default_nettype none
module test_psumb_regs
	import psumb_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int TC = 3;
	logic clk, rst, req_valid, rsp_valid, meas_valid, remote_sense_on;
	logic power_enable, ov;
	logic [7:0] req_func, req_count, rsp_func, rsp_exc_code, rsp_count;
	logic [7:0] of, oe, on;
	logic [15:0] req_addr, quest_word;
	logic [31:0] req_wdata, meas_current, meas_voltage, sense_voltage;
	logic [31:0] meas_power, current_target, voltage_target, power_target;
	logic [63:0] rsp_data, od;
	logic [11:0] flags;
	logic [15:0] qexp;
	logic [63:0] sexp;
	int err_count, checked;
	int bitpos [12] = '{5, 6, 7, 8, 9, 12, 13, 16, 17, 29, 31, 33};
	psumb_master psumb_master_i (.clk(clk), .req_valid(req_valid),
		.req_func(req_func), .req_addr(req_addr), .req_count(req_count),
		.req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_func(rsp_func),
		.rsp_exc_code(rsp_exc_code), .rsp_count(rsp_count),
		.rsp_data(rsp_data));
	psumb_regs #(.TRIP_COUNT(TC)) psumb_regs_i (.clk(clk), .rst(rst),
		.req_valid(req_valid), .req_func(req_func), .req_addr(req_addr),
		.req_count(req_count), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_func(rsp_func),
		.rsp_exc_code(rsp_exc_code), .rsp_count(rsp_count),
		.rsp_data(rsp_data), .meas_valid(meas_valid),
		.meas_current(meas_current), .meas_voltage(meas_voltage),
		.sense_voltage(sense_voltage), .remote_sense_on(remote_sense_on),
		.meas_power(meas_power), .voltage_high_trip_flag(flags[0]),
		.power_trip_flag(flags[1]), .far_sense_lost_flag(flags[2]),
		.voltage_low_trip_flag(flags[3]), .shutdown_flag(flags[4]),
		.startup_failed_flag(flags[5]), .startup_pending_flag(flags[6]),
		.terminal_current_limit_flag(flags[7]),
		.terminal_voltage_limit_flag(flags[8]),
		.regulation_lost_flag(flags[9]),
		.input_phase_missing_flag(flags[10]), .fan_stall_flag(flags[11]),
		.power_enable(power_enable), .current_target(current_target),
		.voltage_target(voltage_target), .power_target(power_target),
		.quest_word(quest_word));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [63:0] e,
		input logic [63:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] n,
		input logic [63:0] e);
		psumb_master_i.xfer(FC_READ, a, n, 32'h0, ov, of, oe, on, od);
		chk("answer", {1'b1, FC_READ, EXC_NONE, n}, {ov, of, oe, on});
		chk("rsp_data", e, od);
	endtask
	task automatic wr(input logic [7:0] f, input logic [15:0] a,
		input logic [7:0] n, input logic [31:0] w);
		psumb_master_i.xfer(f, a, n, w, ov, of, oe, on, od);
		chk("answer", {1'b1, f, EXC_NONE, n}, {ov, of, oe, on});
		chk("echo", {32'h0, w}, od);
	endtask
	task automatic bad(input logic [7:0] f, input logic [15:0] a,
		input logic [7:0] n, input logic [31:0] w, input logic [7:0] x);
		psumb_master_i.xfer(f, a, n, w, ov, of, oe, on, od);
		chk("refusal", {1'b1, f | EXC_FLAG, x, CNT_NONE}, {ov, of, oe, on});
	endtask
	task automatic smp(input logic [31:0] i);
		@(posedge clk);
		#1;
		meas_valid = 1'b1;
		meas_current = i;
		@(posedge clk);
		#1;
		meas_valid = 1'b0;
	endtask
	task automatic conclude();
		$display("checked %0d err_count %0d", checked, err_count);
		if (err_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		meas_valid = 1'b0;
		meas_current = 32'h3F800000;
		meas_voltage = 32'h41200000;
		sense_voltage = 32'h41100000;
		meas_power = 32'h40A00000;
		remote_sense_on = 1'b0;
		flags = 12'h000;
		err_count = 0;
		checked = 0;
		repeat (3) @(posedge clk);
		#1;
		rst = 1'b0;
		rd(ADDR_STATUS, CNT_FOUR, 64'h1);
		rd(ADDR_STATUS, CNT_FOUR, 64'h1);
		wr(FC_WRITE_MANY, ADDR_CUR_WR, CNT_TWO, 32'h3FC00000);
		wr(FC_WRITE_MANY, ADDR_VOLT_WR, CNT_TWO, 32'h42480000);
		wr(FC_WRITE_MANY, ADDR_PWR_WR, CNT_TWO, 32'h447A0000);
		wr(FC_WRITE_MANY, ADDR_TRIP_WR, CNT_TWO, 32'h40000000);
		chk("current_target", 64'h3FC00000, current_target);
		chk("voltage_target", 64'h42480000, voltage_target);
		chk("power_target", 64'h447A0000, power_target);
		rd(ADDR_CUR_RD, CNT_TWO, 64'h3FC00000);
		rd(ADDR_VOLT_RD, CNT_TWO, 64'h42480000);
		rd(ADDR_PWR_RD, CNT_TWO, 64'h447A0000);
		rd(ADDR_TRIP_RD, CNT_TWO, 64'h40000000);
		bad(8'h04, ADDR_STATUS, CNT_FOUR, 32'h0, EXC_FUNC);
		bad(FC_READ, ADDR_OUT_WR, CNT_ONE, 32'h0, EXC_ADDR);
		bad(FC_READ, 16'h5000, CNT_TWO, 32'h0, EXC_ADDR);
		bad(FC_WRITE_MANY, ADDR_CUR_RD, CNT_TWO, 32'h1, EXC_ADDR);
		bad(FC_WRITE_MANY, ADDR_CUR_WR, CNT_ONE, 32'h1, EXC_DATA);
		bad(FC_WRITE_ONE, ADDR_OUT_WR, CNT_ONE, 32'h2, EXC_DATA);
		bad(FC_READ, ADDR_STATUS, CNT_TWO, 32'h0, EXC_DATA);
		rd(ADDR_CUR_RD, CNT_TWO, 64'h3FC00000);
		chk("power_enable", 64'h0, power_enable);
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			#1;
			flags = 12'h001 << i;
			repeat (3) @(posedge clk);
			sexp = 64'h1 | (64'h1 << bitpos[i]);
			rd(ADDR_STATUS, CNT_FOUR, sexp);
			qexp = (i == 0) ? 16'h0004 : (i == 1) ? 16'h0008 :
				(i == 2) ? 16'h0040 : 16'h0000;
			chk("quest_word", qexp, quest_word);
		end
		flags = 12'h000;
		repeat (3) @(posedge clk);
		rd(ADDR_STATUS, CNT_FOUR, 64'h1);
		smp(32'h3F800000);
		rd(ADDR_MEAS_I, CNT_TWO, 64'h3F800000);
		rd(ADDR_MEAS_V, CNT_TWO, 64'h41200000);
		rd(ADDR_MEAS_P, CNT_TWO, 64'h40A00000);
		remote_sense_on = 1'b1;
		// the voltage reading is latched with each sample
		smp(32'h3F800000);
		rd(ADDR_MEAS_V, CNT_TWO, 64'h41100000);
		wr(FC_WRITE_ONE, ADDR_OUT_WR, CNT_ONE, 32'h1);
		chk("power_enable", 64'h1, power_enable);
		rd(ADDR_STATUS, CNT_FOUR, 64'h2);
		rd(ADDR_OUT_RD, CNT_ONE, 64'h1);
		smp(32'h40400000);
		smp(32'h40400000);
		smp(32'h3F800000);
		smp(32'h40400000);
		smp(32'h40400000);
		chk("power_enable", 64'h1, power_enable);
		smp(32'h40400000);
		chk("power_enable", 64'h0, power_enable);
		rd(ADDR_STATUS, CNT_FOUR, 64'h11);
		rd(ADDR_OUT_RD, CNT_ONE, 64'h0);
		wr(FC_WRITE_ONE, ADDR_OUT_WR, CNT_ONE, 32'h0);
		rd(ADDR_STATUS, CNT_FOUR, 64'h1);
		conclude();
	end
endmodule // test_psumb_regs
`default_nettype wire
